/* File: rtl/hbp_host_port.v */
// host pin interface: parallel bus, serial access, interrupt and straps
`include "hbp_map.vh"

module hbp_host_port (
    mclk,
    nrst,
    hostAddr,
    hostDataIn,
    hostDataOut,
    hostDataOe_n,
    hostCs_n,
    hostWr_n,
    hostRd_n,
    hostInt_n,
    serialPortEnable,
    serialClk,
    serialSelect_n,
    serialMosi,
    serialMiso,
    serialMisoOe_n,
    factoryModeStrap,
    factoryTest,
    evtConnect,
    evtDisconnect,
    evtRecv,
    evtTimeout
);
    input  wire        mclk;
    input  wire        nrst;
    input  wire [14:0] hostAddr;
    input  wire [7:0]  hostDataIn;
    output wire [7:0]  hostDataOut;
    output wire        hostDataOe_n;
    input  wire        hostCs_n;
    input  wire        hostWr_n;
    input  wire        hostRd_n;
    output wire        hostInt_n;
    input  wire        serialPortEnable;
    input  wire        serialClk;
    input  wire        serialSelect_n;
    input  wire        serialMosi;
    output wire        serialMiso;
    output wire        serialMisoOe_n;
    input  wire [3:0]  factoryModeStrap;
    output wire        factoryTest;
    input  wire [3:0]  evtConnect;
    input  wire [3:0]  evtDisconnect;
    input  wire [3:0]  evtRecv;
    input  wire [3:0]  evtTimeout;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    reg  [1:0]  rstPipe_ff;
    reg  [31:0] pinMeta_ff;
    reg  [31:0] pinSync_ff;
    reg         wrPrev_ff;
    reg         csPrev_ff;
    reg  [7:0]  dataOut_ff;
    reg         int_ff;
    reg         test_ff;
    reg  [3:0]  gMask_ff;
    reg  [15:0] sockIrq_ff;
    reg  [7:0]  rdMux;
    reg  [7:0]  cmnMem  [0:`HBP_CMN_DEPTH-1];
    reg  [7:0]  sockMem [0:`HBP_SOCK_DEPTH-1];
    reg  [7:0]  txMem   [0:`HBP_BUF_DEPTH-1];
    reg  [7:0]  rxMem   [0:`HBP_BUF_DEPTH-1];
    wire        rstN;
    wire [14:0] addrS;
    wire [7:0]  dataS;
    wire        csS;
    wire        wrS;
    wire        rdS;
    wire        senS;
    wire [3:0]  strapS;
    wire        parWr;
    wire        spiWr;
    wire [14:0] spiAddr;
    wire [7:0]  spiData;
    wire        wrEn;
    wire [14:0] wrAddr;
    wire [7:0]  wrData;
    wire [3:0]  wrRegion;
    wire [14:0] rdAddr;
    wire [3:0]  rdRegion;
    wire        gHit;
    wire [3:0]  gFlag;
    wire [15:0] nxt_sockIrq;
    integer     i;

    // region decode: bit0 common, bit1 socket, bit2 tx, bit3 rx
    function [3:0] regionOf;
        input [14:0] a;
        begin
            regionOf = 4'h0;
            if (a < `HBP_CMN_END) begin
                regionOf = 4'h1;
            end else if (a >= `HBP_SOCK_BASE && a < `HBP_SOCK_END) begin
                regionOf = 4'h2;
            end else if (a >= `HBP_TX_BASE && a < `HBP_RX_BASE) begin
                regionOf = 4'h4;
            end else if (a >= `HBP_RX_BASE) begin
                regionOf = 4'h8;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    // async assert, two-flop release of the reset pin
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstPipe_ff <= 2'h0;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end
    assign rstN = rstPipe_ff[1];

    // all host pins pass two flops; address pads resolve undriven to zero
    // select and strobes reset to their idle high level, so no false edge
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            pinMeta_ff <= 32'h0380_0000;
            pinSync_ff <= 32'h0380_0000;
        end else begin
            pinMeta_ff <= {1'b0, factoryModeStrap, serialPortEnable,
                           hostRd_n, hostWr_n, hostCs_n, hostDataIn,
                           hostAddr};
            pinSync_ff <= pinMeta_ff;
        end
    end
    assign addrS  = pinSync_ff[14:0];
    assign dataS  = pinSync_ff[22:15];
    assign csS    = pinSync_ff[23];
    assign wrS    = pinSync_ff[24];
    assign rdS    = pinSync_ff[25];
    assign senS   = pinSync_ff[26];
    assign strapS = pinSync_ff[30:27];

    ////////////////////////////////////////////////////////////////////////
    // access selection between parallel bus and serial slave

    // write strobe rising edge while chip select was low
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            wrPrev_ff <= 1'b1;
            csPrev_ff <= 1'b1;
        end else begin
            wrPrev_ff <= wrS;
            csPrev_ff <= csS;
        end
    end
    assign parWr = ~senS & ~csPrev_ff & wrS & ~wrPrev_ff;

    hbp_spi_slave uSpi (
        .mclk           (mclk),
        .rstN           (rstN),
        .spiEnable      (senS),
        .serialClk      (serialClk),
        .serialSelect_n (serialSelect_n),
        .serialMosi     (serialMosi),
        .serialMiso     (serialMiso),
        .serialMisoOe_n (serialMisoOe_n),
        .rdData         (rdMux),
        .reqAddr        (spiAddr),
        .reqData        (spiData),
        .reqWr          (spiWr),
        .reqRd          ()
    );

    // serial enable strap picks the active path
    assign wrEn     = senS ? spiWr : parWr;
    assign wrAddr   = senS ? spiAddr : addrS;
    assign wrData   = senS ? spiData : dataS;
    assign rdAddr   = senS ? spiAddr : addrS;
    assign wrRegion = regionOf(wrAddr);
    assign rdRegion = regionOf(rdAddr);

    ////////////////////////////////////////////////////////////////////////
    // register and buffer storage

    // common and socket registers return to zero on reset
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            for (i = 0; i < `HBP_CMN_DEPTH; i = i + 1) begin
                cmnMem[i] <= `HBP_BYTE_RST;
            end
            for (i = 0; i < `HBP_SOCK_DEPTH; i = i + 1) begin
                sockMem[i] <= `HBP_BYTE_RST;
            end
        end else if (wrEn) begin
            if (wrRegion[0]) begin
                cmnMem[wrAddr[5:0]] <= wrData;
            end
            if (wrRegion[1]) begin
                sockMem[wrAddr[9:0]] <= wrData;
            end
        end
    end

    // buffer memories hold no reset state
    always @(posedge mclk) begin
        if (wrEn && wrRegion[2]) begin
            txMem[wrAddr[12:0]] <= wrData;
        end
        if (wrEn && wrRegion[3]) begin
            rxMem[wrAddr[12:0]] <= wrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags and mask

    assign gHit = wrEn && wrAddr == `HBP_GIRQ_ADDR;

    // per socket: set wins over a clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gSock
            localparam [1:0] SN = g;
            wire [3:0] setV;
            wire [3:0] clrV;
            wire       sHit;
            assign setV = {evtTimeout[g], evtRecv[g],
                           evtDisconnect[g], evtConnect[g]};
            assign sHit = wrEn && wrRegion[1] && wrAddr[9:8] == SN &&
                          wrAddr[7:0] == `HBP_SIRQ_OFS;
            assign clrV = (sHit ? wrData[3:0] : 4'h0) |
                          ((gHit && wrData[g]) ? 4'hF : 4'h0);
            assign nxt_sockIrq[4*g+3:4*g] =
                (sockIrq_ff[4*g+3:4*g] & ~clrV) | setV;
            assign gFlag[g] = |sockIrq_ff[4*g+3:4*g];
        end
    endgenerate

    // flag, mask, interrupt pin and factory strap status
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            sockIrq_ff <= {4{`HBP_SIRQ_RST}};
            gMask_ff   <= `HBP_GMASK_RST;
            int_ff     <= 1'b0;
            test_ff    <= 1'b0;
        end else begin
            sockIrq_ff <= nxt_sockIrq;
            if (wrEn && wrAddr == `HBP_GMASK_ADDR) begin
                gMask_ff <= wrData[3:0];
            end
            int_ff  <= |(gFlag & gMask_ff);
            test_ff <= strapS != `HBP_STRAP_NORMAL;
        end
    end
    assign hostInt_n   = ~int_ff;
    assign factoryTest = test_ff;

    ////////////////////////////////////////////////////////////////////////
    // read path

    // addressed byte with flag and mask registers overlaid
    always @* begin
        rdMux = 8'h00;
        if (rdAddr == `HBP_GIRQ_ADDR) begin
            rdMux = {4'h0, gFlag};
        end else if (rdAddr == `HBP_GMASK_ADDR) begin
            rdMux = {4'h0, gMask_ff};
        end else if (rdRegion[1] && rdAddr[7:0] == `HBP_SIRQ_OFS) begin
            rdMux = {4'h0, sockIrq_ff[{rdAddr[9:8], 2'h0} +: 4]};
        end else begin
            case (rdRegion)
                4'h1:    rdMux = cmnMem[rdAddr[5:0]];
                4'h2:    rdMux = sockMem[rdAddr[9:0]];
                4'h4:    rdMux = txMem[rdAddr[12:0]];
                4'h8:    rdMux = rxMem[rdAddr[12:0]];
                default: rdMux = 8'h00;
            endcase
        end
    end

    // registered byte follows the current address while read is held
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            dataOut_ff <= 8'h00;
        end else begin
            dataOut_ff <= rdMux;
        end
    end
    assign hostDataOut  = dataOut_ff;
    assign hostDataOe_n = ~(~senS & ~csS & ~rdS);
endmodule // hbp_host_port

/* File: shared/hbp_map.vh */
// address map, field positions, reset values and timing counts of the host port
`ifndef HBP_MAP_VH
`define HBP_MAP_VH

// region boundaries of the 15-bit host address space
`define HBP_CMN_BASE      15'h0000
`define HBP_CMN_END       15'h0030
`define HBP_SOCK_BASE     15'h0400
`define HBP_SOCK_END      15'h0800
`define HBP_TX_BASE       15'h4000
`define HBP_RX_BASE       15'h6000

// array depths of each region
`define HBP_CMN_DEPTH     48
`define HBP_SOCK_DEPTH    1024
`define HBP_BUF_DEPTH     8192

// interrupt register locations
`define HBP_GIRQ_ADDR     15'h0015
`define HBP_GMASK_ADDR    15'h0016
`define HBP_SIRQ_OFS      8'h02

// per-socket flag bit positions
`define HBP_SIRQ_CON      0
`define HBP_SIRQ_DISCON   1
`define HBP_SIRQ_RECV     2
`define HBP_SIRQ_TMO      3

// reset values
`define HBP_SIRQ_RST      4'h0
`define HBP_GMASK_RST     4'h0
`define HBP_BYTE_RST      8'h00

// serial frame layout
`define HBP_OP_WRITE      8'hF0
`define HBP_OP_READ       8'h0F
`define HBP_RD_BITS       6'h18
`define HBP_FRAME_BITS    6'h20

// straps and reset timing
`define HBP_STRAP_NORMAL  4'h0
`define HBP_CLK_NS        25
`define HBP_RST_MIN_NS    2000
`define HBP_RST_MIN_CYC   ((`HBP_RST_MIN_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)

`endif

/* File: rtl/hbp_spi_slave.v */
// serial-peripheral slave, clock mode 0, oversampled on the system clock
`include "hbp_map.vh"

module hbp_spi_slave (
    mclk,
    rstN,
    spiEnable,
    serialClk,
    serialSelect_n,
    serialMosi,
    serialMiso,
    serialMisoOe_n,
    rdData,
    reqAddr,
    reqData,
    reqWr,
    reqRd
);
    input  wire        mclk;
    input  wire        rstN;
    input  wire        spiEnable;
    input  wire        serialClk;
    input  wire        serialSelect_n;
    input  wire        serialMosi;
    output wire        serialMiso;
    output wire        serialMisoOe_n;
    input  wire [7:0]  rdData;
    output wire [14:0] reqAddr;
    output wire [7:0]  reqData;
    output wire        reqWr;
    output wire        reqRd;

    reg  [2:0]  meta_ff;
    reg  [2:0]  sync_ff;
    reg         clkPrev_ff;
    reg  [5:0]  bitCnt_ff;
    reg  [31:0] inSh_ff;
    reg  [7:0]  outSh_ff;
    reg         miso_ff;
    reg         load_ff;
    reg         reqWr_ff;
    reg         reqRd_ff;
    reg  [14:0] reqAddr_ff;
    reg  [7:0]  reqData_ff;
    wire        sclkS;
    wire        selS;
    wire        mosiS;
    wire        active;
    wire        rise;
    wire        fall;
    wire [31:0] nxt_inSh;

    assign sclkS    = sync_ff[0];
    assign selS     = sync_ff[1];
    assign mosiS    = sync_ff[2];
    assign active   = spiEnable & ~selS;
    assign rise     = active & sclkS & ~clkPrev_ff;
    assign fall     = active & ~sclkS & clkPrev_ff;
    assign nxt_inSh = {inSh_ff[30:0], mosiS};

    // two-stage synchronisers for the serial pins
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            meta_ff <= 3'h2;
            sync_ff <= 3'h2;
        end else begin
            meta_ff <= {serialMosi, serialSelect_n, serialClk};
            sync_ff <= meta_ff;
        end
    end

    // shift in on rising edges, shift out on falling edges
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            clkPrev_ff <= 1'b0;
            bitCnt_ff  <= 6'h00;
            inSh_ff    <= 32'h0000_0000;
            outSh_ff   <= 8'h00;
            miso_ff    <= 1'b0;
            load_ff    <= 1'b0;
            reqWr_ff   <= 1'b0;
            reqRd_ff   <= 1'b0;
            reqAddr_ff <= 15'h0000;
            reqData_ff <= 8'h00;
        end else begin
            clkPrev_ff <= sclkS;
            reqWr_ff   <= 1'b0;
            reqRd_ff   <= 1'b0;
            load_ff    <= reqRd_ff;
            if (!active) begin
                bitCnt_ff <= 6'h00;
            end else if (rise) begin
                inSh_ff   <= nxt_inSh;
                bitCnt_ff <= bitCnt_ff + 6'h01;
                if (bitCnt_ff == `HBP_RD_BITS - 6'h01 &&
                    nxt_inSh[23:16] == `HBP_OP_READ) begin
                    reqAddr_ff <= nxt_inSh[14:0];
                    reqRd_ff   <= 1'b1;
                end
                if (bitCnt_ff == `HBP_FRAME_BITS - 6'h01) begin
                    bitCnt_ff <= 6'h00;
                    if (nxt_inSh[31:24] == `HBP_OP_WRITE) begin
                        reqAddr_ff <= nxt_inSh[22:8];
                        reqData_ff <= nxt_inSh[7:0];
                        reqWr_ff   <= 1'b1;
                    end
                end
            end else if (fall && bitCnt_ff > `HBP_RD_BITS) begin
                miso_ff  <= outSh_ff[7];
                outSh_ff <= {outSh_ff[6:0], 1'b0};
            end
            // read byte arrives one cycle after the request
            if (load_ff) begin
                miso_ff  <= rdData[7];
                outSh_ff <= {rdData[6:0], 1'b0};
            end
        end
    end

    assign serialMiso     = miso_ff;
    assign serialMisoOe_n = ~active;
    assign reqAddr        = reqAddr_ff;
    assign reqData        = reqData_ff;
    assign reqWr          = reqWr_ff;
    assign reqRd          = reqRd_ff;
endmodule // hbp_spi_slave

/* File: verification/hbp_host_port_properties.sv */
// concurrent checks on the pins of the host port
module hbp_host_port_properties (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        hostCs_n,
    input wire logic        hostWr_n,
    input wire logic        hostRd_n,
    input wire logic [7:0]  hostDataOut,
    input wire logic        hostDataOe_n,
    input wire logic        hostInt_n,
    input wire logic        serialPortEnable,
    input wire logic        serialSelect_n,
    input wire logic        serialMisoOe_n,
    input wire logic [3:0]  factoryModeStrap,
    input wire logic        factoryTest,
    input wire logic [3:0]  evtConnect,
    input wire logic [3:0]  evtDisconnect,
    input wire logic [3:0]  evtRecv,
    input wire logic [3:0]  evtTimeout
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////
    // read cycle held long enough to pass the pin synchronisers
    sequence s_readHeld;
        (!hostCs_n && !hostRd_n && !serialPortEnable)[*4];
    endsequence
    // no write strobe, no serial frame and no event for a while
    sequence s_quiet;
        (hostWr_n && serialSelect_n
         && !(|{evtConnect, evtDisconnect, evtRecv, evtTimeout}))[*8];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // outputs at rest while reset is held, checked even during reset
    property p_rstOut;
        disable iff (1'b0)
        (!nrst)[*2] |-> hostInt_n && hostDataOe_n && serialMisoOe_n
                  && !factoryTest && hostDataOut == 8'h00;
    endproperty
    property p_readDrive;
        s_readHeld |=> !hostDataOe_n;
    endproperty
    property p_csRel;
        hostCs_n[*4] |=> hostDataOe_n;
    endproperty
    property p_rdRel;
        hostRd_n[*4] |=> hostDataOe_n;
    endproperty
    property p_strapRel;
        serialPortEnable[*4] |=> hostDataOe_n;
    endproperty
    property p_misoSel;
        serialSelect_n[*4] |=> serialMisoOe_n;
    endproperty
    property p_misoOff;
        (!serialPortEnable)[*4] |=> serialMisoOe_n;
    endproperty
    property p_strapOk;
        (factoryModeStrap == 4'h0)[*5] |=> !factoryTest;
    endproperty
    property p_strapBad;
        (factoryModeStrap != 4'h0)[*5] |=> factoryTest;
    endproperty
    property p_intQuiet;
        s_quiet |=> $stable(hostInt_n);
    endproperty

    a_rstOut: assert property (p_rstOut)
        else $error("outputs not at rest during reset");
    a_readDrive: assert property (p_readDrive)
        else $error("data bus not driven during read");
    a_csRel: assert property (p_csRel)
        else $error("data bus driven without chip select");
    a_rdRel: assert property (p_rdRel)
        else $error("data bus driven without read strobe");
    a_strapRel: assert property (p_strapRel)
        else $error("parallel bus driven in serial mode");
    a_misoSel: assert property (p_misoSel)
        else $error("serial out driven while deselected");
    a_misoOff: assert property (p_misoOff)
        else $error("serial out driven with serial mode off");
    a_strapOk: assert property (p_strapOk)
        else $error("test flag set with normal strap");
    a_strapBad: assert property (p_strapBad)
        else $error("test flag clear with test strap");
    a_intQuiet: assert property (p_intQuiet)
        else $error("interrupt moved without cause");
endmodule // hbp_host_port_properties

bind hbp_host_port hbp_host_port_properties u_hbp_host_port_properties (
    .mclk(mclk), .nrst(nrst), .hostCs_n(hostCs_n), .hostWr_n(hostWr_n),
    .hostRd_n(hostRd_n), .hostDataOut(hostDataOut),
    .hostDataOe_n(hostDataOe_n), .hostInt_n(hostInt_n),
    .serialPortEnable(serialPortEnable), .serialSelect_n(serialSelect_n),
    .serialMisoOe_n(serialMisoOe_n), .factoryModeStrap(factoryModeStrap),
    .factoryTest(factoryTest), .evtConnect(evtConnect),
    .evtDisconnect(evtDisconnect), .evtRecv(evtRecv),
    .evtTimeout(evtTimeout));

/* File: verification/hbp_mcu_model.sv */
// microcontroller model: parallel bus master and mode 0 serial master
module hbp_mcu_model (
    input  logic        mclk,
    output logic [14:0] hostAddr,
    output logic [7:0]  hostDataIn,
    input  logic [7:0]  hostDataOut,
    input  logic        hostDataOe_n,
    output logic        hostCs_n,
    output logic        hostWr_n,
    output logic        hostRd_n,
    output logic        serialClk,
    output logic        serialSelect_n,
    output logic        serialMosi,
    input  logic        serialMiso
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] drvData = 8'h00;
    logic       drvOn = 1'b0;

    // shared data wire; a released wire shows the inverse of the last byte
    assign hostDataIn = !hostDataOe_n ? hostDataOut
                        : drvOn ? drvData : ~drvData;

    // idle levels: strobes high, serial clock low, deselected
    initial begin
        hostAddr = 15'h0000;
        hostCs_n = 1'b1;
        hostWr_n = 1'b1;
        hostRd_n = 1'b1;
        serialClk = 1'b0;
        serialSelect_n = 1'b1;
        serialMosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // single byte write, data taken at the write strobe rising edge
    task automatic busWrite(input logic [14:0] a, input logic [7:0] d,
                            input logic sel_n);
        hostAddr = a;
        drvData = d;
        drvOn = 1'b1;
        hostCs_n = sel_n;
        hostWr_n = 1'b0;
        step(4);
        hostWr_n = 1'b1;
        step(2);
        hostCs_n = 1'b1;
        drvOn = 1'b0;
        step(4);
    endtask
    // single byte read, wire level sampled while the strobe is held
    task automatic busRead(input logic [14:0] a, input logic sel_n,
                           output logic [7:0] d, output logic oe_n);
        hostAddr = a;
        hostCs_n = sel_n;
        hostRd_n = 1'b0;
        step(6);
        d = hostDataIn;
        oe_n = hostDataOe_n;
        hostRd_n = 1'b1;
        step(1);
        hostCs_n = 1'b1;
        step(4);
    endtask
    // 32-bit frame msb first, clock idles low, master shifts when low
    task automatic spiFrame(input logic [31:0] f, input logic sel_n,
                            output logic [7:0] r);
        serialSelect_n = sel_n;
        step(8);
        for (int i = 31; i >= 0; i--) begin
            serialMosi = f[i];
            step(8);
            serialClk = 1'b1;
            if (i < 8) r[i] = serialMiso;
            step(8);
            serialClk = 1'b0;
        end
        step(8);
        serialSelect_n = 1'b1;
        serialMosi = ~serialMosi;
        step(8);
    endtask
endmodule // hbp_mcu_model

/* File: verification/tb_top.sv */
// self-checking bench for the host pin interface
`include "hbp_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        serialPortEnable = 1'b0;
    logic [3:0]  factoryModeStrap = `HBP_STRAP_NORMAL;
    logic [15:0] evtAll = 16'h0000;
    logic [14:0] hostAddr;
    logic [7:0]  hostDataIn;
    logic [7:0]  hostDataOut;
    logic        hostDataOe_n;
    logic        hostCs_n;
    logic        hostWr_n;
    logic        hostRd_n;
    logic        hostInt_n;
    logic        serialClk;
    logic        serialSelect_n;
    logic        serialMosi;
    logic        serialMiso;
    logic        serialMisoOe_n;
    logic        factoryTest;
    int          nFail = 0;
    int          checksDone = 0;
    int          cycles = 0;

    always #12.5 mclk = ~mclk;

    hbp_host_port u_hbp_host_port (
        .mclk(mclk), .nrst(nrst), .hostAddr(hostAddr),
        .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
        .hostDataOe_n(hostDataOe_n), .hostCs_n(hostCs_n),
        .hostWr_n(hostWr_n), .hostRd_n(hostRd_n), .hostInt_n(hostInt_n),
        .serialPortEnable(serialPortEnable), .serialClk(serialClk),
        .serialSelect_n(serialSelect_n), .serialMosi(serialMosi),
        .serialMiso(serialMiso), .serialMisoOe_n(serialMisoOe_n),
        .factoryModeStrap(factoryModeStrap), .factoryTest(factoryTest),
        .evtConnect(evtAll[3:0]), .evtDisconnect(evtAll[7:4]),
        .evtRecv(evtAll[11:8]), .evtTimeout(evtAll[15:12]));

    hbp_mcu_model u_hbp_mcu_model (
        .mclk(mclk), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
        .hostDataOut(hostDataOut), .hostDataOe_n(hostDataOe_n),
        .hostCs_n(hostCs_n), .hostWr_n(hostWr_n), .hostRd_n(hostRd_n),
        .serialClk(serialClk), .serialSelect_n(serialSelect_n),
        .serialMosi(serialMosi), .serialMiso(serialMiso));

    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        u_hbp_mcu_model.busWrite(a, d, 1'b0);
    endtask
    task automatic rdck(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       oe;
        u_hbp_mcu_model.busRead(a, 1'b0, d, oe);
        check(d, e);
    endtask
    task automatic pulse(input int kind, input int sock);
        evtAll[kind * 4 + sock] = 1'b1;
        step(1);
        evtAll = 16'h0000;
        step(3);
    endtask
    task automatic doReset;
        nrst = 1'b0;
        step(`HBP_RST_MIN_CYC);
        nrst = 1'b1;
        step(8);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_map;
        logic [14:0] adr [10];
        adr = '{15'h0001, 15'h0405, 15'h4000, 15'h5FFF, 15'h6000,
                15'h7FFF, 15'h0030, 15'h03FF, 15'h0800, 15'h3FFF};
        check(hostInt_n, 1'b1);
        rdck(15'h0000, 8'h00);
        for (int i = 0; i < 10; i++) wr(adr[i], 8'hA0 + 8'(i));
        for (int i = 0; i < 10; i++) begin
            rdck(adr[i], (i < 6) ? 8'hA0 + 8'(i) : 8'h00);
        end
        $display("map test done");
    endtask
    task automatic t_gate;
        logic [7:0] d;
        logic       oe;
        u_hbp_mcu_model.busWrite(15'h0001, 8'h55, 1'b1);
        rdck(15'h0001, 8'hA0);
        u_hbp_mcu_model.busRead(15'h0001, 1'b1, d, oe);
        check(oe, 1'b1);
        u_hbp_mcu_model.busRead(15'h0001, 1'b0, d, oe);
        check(oe, 1'b0);
        $display("select test done");
    endtask
    task automatic t_irq;
        wr(15'h0016, 8'h01);
        for (int k = 0; k < 4; k++) begin
            pulse(k, 0);
            check(hostInt_n, 1'b0);
            rdck(15'h0402, 8'h01 << k);
            wr(15'h0402, 8'h01 << k);
            check(hostInt_n, 1'b1);
        end
        pulse(0, 1);
        check(hostInt_n, 1'b1);
        rdck(15'h0015, 8'h02);
        wr(15'h0016, 8'h02);
        check(hostInt_n, 1'b0);
        wr(15'h0015, 8'h02);
        check(hostInt_n, 1'b1);
        rdck(15'h0502, 8'h00);
        $display("interrupt test done");
    endtask
    task automatic t_spi;
        logic [7:0] d;
        logic       oe;
        serialPortEnable = 1'b1;
        step(4);
        u_hbp_mcu_model.spiFrame({8'hF0, 16'h0003, 8'h3C}, 1'b0, d);
        u_hbp_mcu_model.spiFrame({8'h0F, 16'h0003, 8'h00}, 1'b0, d);
        check(d, 8'h3C);
        u_hbp_mcu_model.spiFrame({8'hF0, 16'h0003, 8'h99}, 1'b1, d);
        u_hbp_mcu_model.spiFrame({8'h0F, 16'h8003, 8'h00}, 1'b0, d);
        check(d, 8'h3C);
        u_hbp_mcu_model.busRead(15'h0003, 1'b0, d, oe);
        check(oe, 1'b1);
        serialPortEnable = 1'b0;
        step(4);
        rdck(15'h0003, 8'h3C);
        $display("serial test done");
    endtask
    task automatic t_strap;
        factoryModeStrap = 4'h5;
        step(6);
        check(factoryTest, 1'b1);
        factoryModeStrap = `HBP_STRAP_NORMAL;
        step(6);
        check(factoryTest, 1'b0);
        doReset();
        rdck(15'h0001, 8'h00);
        $display("strap and reset test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic giveVerdict;
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nFail = nFail + 1;
            giveVerdict();
        end
    end
    // main sequence
    initial begin
        doReset();
        t_map();
        t_gate();
        t_irq();
        t_spi();
        t_strap();
        giveVerdict();
    end
endmodule // tb_top
